/* hw/clk_lp_ctrl.sv */
`timescale 1ns/1ps
module clk_lp_ctrl
  import clk_lp_pkg::*;
#(
  parameter logic CLK_OPTION = 1'b0  // 0: main oscillator, 1: clock function oscillator
)(
  input  wire logic              CLK_IN,
  input  wire logic              SYS_RST_IN,
  input  wire logic              MAIN_OSC_IN,                 // main oscillator level
  input  wire logic              CLOCK_FUNCTION_OSC_INPUT_IN, // clock function oscillator level
  input  wire logic              WAIT_INSTRUCTION_IN,         // pulse from core
  input  wire logic              STOP_INSTRUCTION_IN,         // pulse from core
  input  wire logic              WAKE_IRQ_IN,                 // any enabled interrupt
  input  wire logic [WAKE_W-1:0] STOP_WAKE_IN,                // ext 1..4, serial 1
  input  wire logic              WB_CYC_IN,
  input  wire logic              WB_STB_IN,
  input  wire logic              WB_WE_IN,
  input  wire logic [ADR_W-1:0]  WB_ADR_IN,
  input  wire logic [SEL_W-1:0]  WB_SEL_IN,
  input  wire logic [DAT_W-1:0]  WB_DAT_IN,
  output logic      [DAT_W-1:0]  WB_DAT_OUT,
  output logic                   WB_ACK_OUT,
  output logic                   PHI_OUT,          // internal system clock level
  output logic                   PHI_RISE_OUT,     // one-cycle pulse at each divider-driven phi rise
  output logic                   MAIN_OSC_EN_OUT,  // main oscillator runs
  output logic                   CFO_EN_OUT,       // clock function oscillator runs
  output logic                   T3_OVF_OUT        // stabilisation overflow pulse
);

  wb_req_t          req;            // bundled bus request
  lp_state_t        state_r;        // low power state
  lp_state_t        state_nxt;      // next low power state
  osc_tick_t        tick;           // oscillator events
  logic [REG_W-1:0] ser1_mode_r;    // source select register
  logic [REG_W-1:0] ser2_mode_r;    // halt register
  logic [REG_W-1:0] t3_pre_rld_r;   // prescaler reload n
  logic [REG_W-1:0] t3_cnt_rld_r;   // timer 3 reload n
  logic [REG_W-1:0] tmr_ctrl_r;     // timer control
  logic [REG_W-1:0] t3_pre_r;       // prescaler down counter
  logic [REG_W-1:0] t3_cnt_r;       // timer 3 down counter
  logic [REG_W-1:0] rd_val;         // selected read value
  logic [REG_W-1:0] status_val;     // live state view
  logic [IDX_W-1:0] idx;            // register index
  logic             adr_ok;         // upper address bits clear
  logic             main_prev_r;    // main level one cycle ago
  logic             cfo_prev_r;     // clock function level one cycle ago
  logic [3:0]       main_div_r;     // main edge counter
  logic [2:0]       cfo_div_r;      // clock function edge counter
  logic             main_edge;      // main rising edge
  logic             cfo_edge;       // clock function rising edge
  logic             src_cfo;        // phi from clock function oscillator
  logic             phi_r;          // phi level
  logic             phi_tick;       // event that toggles phi
  logic             t3_tick;        // prescaler input event
  logic             t3_ovf;         // timer 3 underflow
  logic             wr_en;          // write commits this edge

  assign req = '{cyc: WB_CYC_IN, stb: WB_STB_IN, we: WB_WE_IN,
                 adr: WB_ADR_IN, sel: WB_SEL_IN, dat: WB_DAT_IN};

  // register index decode
  assign idx    = req.adr[IDX_LSB +: IDX_W];
  assign adr_ok = (req.adr[ADR_W-1:IDX_LSB+IDX_W] == '0);
  // write commits at the edge where ack is high
  assign wr_en  = req.cyc && req.stb && req.we && WB_ACK_OUT && req.sel[0] && adr_ok;

  // source select from serial 1 mode register
  // bit 7 picks source
  assign src_cfo = ser1_mode_r[BIT_SRC_SEL];

  // oscillator enables
  always_comb
  begin
    MAIN_OSC_EN_OUT = !ser2_mode_r[BIT_MAIN_HALT];
    CFO_EN_OUT      = 1'b1;
    if (state_r == ST_STOP)
    begin
      MAIN_OSC_EN_OUT = 1'b0;
      CFO_EN_OUT      = 1'b0;
    end
  end

  // edges count only while the oscillator is enabled
  assign main_edge = MAIN_OSC_IN && !main_prev_r && MAIN_OSC_EN_OUT;
  assign cfo_edge  = CLOCK_FUNCTION_OSC_INPUT_IN && !cfo_prev_r && CFO_EN_OUT;

  // previous oscillator levels
  always_ff @(posedge CLK_IN or posedge SYS_RST_IN)
  begin
    if (SYS_RST_IN)
    begin
      main_prev_r <= 1'b0;
      cfo_prev_r  <= 1'b0;
    end
    else
    begin
      main_prev_r <= MAIN_OSC_IN;
      cfo_prev_r  <= CLOCK_FUNCTION_OSC_INPUT_IN;
    end
  end

  // oscillator edge counters
  always_ff @(posedge CLK_IN or posedge SYS_RST_IN)
  begin
    if (SYS_RST_IN)
    begin
      main_div_r <= '0;
      cfo_div_r  <= '0;
    end
    else
    begin
      if (main_edge)
        main_div_r <= main_div_r + 4'h1;
      if (cfo_edge)
        cfo_div_r <= cfo_div_r + 3'h1;
    end
  end

  // per-source events
  assign tick.main_phi = main_edge && main_div_r[0];
  assign tick.main_t3  = main_edge && (main_div_r == MAIN_T3_LAST);
  assign tick.cfo_phi  = cfo_edge;
  assign tick.cfo_t3   = cfo_edge && (cfo_div_r == CFO_T3_LAST);

  // phi toggles every 2 main or 1 cfo edge
  assign phi_tick = src_cfo ? tick.cfo_phi : tick.main_phi;
  assign t3_tick  = src_cfo ? tick.cfo_t3 : tick.main_t3;

  // low power state decisions
  always_comb
  begin
    state_nxt = state_r;
    unique case (state_r)
      ST_RUN:
      begin
        if (STOP_INSTRUCTION_IN)
          state_nxt = ST_STOP;
        else if (WAIT_INSTRUCTION_IN)
          state_nxt = ST_WAIT;
      end
      ST_WAIT:
      begin
        if (WAKE_IRQ_IN)
          state_nxt = ST_RUN;
      end
      ST_STOP:
      begin
        if (|STOP_WAKE_IN)
          state_nxt = ST_STAB;
      end
      ST_STAB:
      begin
        // release only on timer 3 overflow
        if (t3_ovf)
          state_nxt = ST_RUN;
      end
    endcase
  end

  // state register
  always_ff @(posedge CLK_IN or posedge SYS_RST_IN)
  begin
    // reset leaves any low power mode
    if (SYS_RST_IN)
      state_r <= ST_RUN;
    else
      state_r <= state_nxt;
  end

  // phi generation
  always_ff @(posedge CLK_IN or posedge SYS_RST_IN)
  begin
    if (SYS_RST_IN)
      phi_r <= 1'b1;
    else if (state_nxt != ST_RUN)
      phi_r <= 1'b1;
    else if (phi_tick)
      phi_r <= !phi_r;
  end

  assign PHI_OUT      = phi_r;
  assign PHI_RISE_OUT = (state_r == ST_RUN) && (state_nxt == ST_RUN) && phi_tick && !phi_r;

  // timer 3 stabilisation counter
  assign t3_ovf = (state_r == ST_STAB) && t3_tick && !tmr_ctrl_r[BIT_T3_STOP]
                  && (t3_pre_r == '0) && (t3_cnt_r == '0);
  assign T3_OVF_OUT = t3_ovf;

  always_ff @(posedge CLK_IN or posedge SYS_RST_IN)
  begin
    if (SYS_RST_IN)
    begin
      t3_pre_r <= RST_T3_PRE;
      t3_cnt_r <= RST_T3_CNT;
    end
    // reload every cycle outside stabilisation
    else if (state_r != ST_STAB)
    begin
      t3_pre_r <= t3_pre_rld_r;
      t3_cnt_r <= t3_cnt_rld_r;
    end
    else if (t3_tick && !tmr_ctrl_r[BIT_T3_STOP])
    begin
      if (t3_pre_r == '0)
      begin
        t3_pre_r <= t3_pre_rld_r;
        if (t3_cnt_r != '0)
          t3_cnt_r <= t3_cnt_r - 8'h01;
      end
      else
        t3_pre_r <= t3_pre_r - 8'h01;
    end
  end

  // software registers, contents kept through stop
  always_ff @(posedge CLK_IN or posedge SYS_RST_IN)
  begin
    // factory option sets source at reset
    if (SYS_RST_IN)
    begin
      ser1_mode_r  <= RST_SER1_MODE | ({{(REG_W-1){1'b0}}, CLK_OPTION} << BIT_SRC_SEL);
      ser2_mode_r  <= RST_SER2_MODE;
      t3_pre_rld_r <= RST_T3_PRE;
      t3_cnt_rld_r <= RST_T3_CNT;
      tmr_ctrl_r   <= RST_TMR_CTRL;
    end
    else if (wr_en)
    begin
      unique case (idx)
        IDX_SER1_MODE: ser1_mode_r  <= req.dat[REG_W-1:0];
        IDX_SER2_MODE: ser2_mode_r  <= req.dat[REG_W-1:0];
        IDX_T3_PRE:    t3_pre_rld_r <= req.dat[REG_W-1:0];
        IDX_T3_CNT:    t3_cnt_rld_r <= req.dat[REG_W-1:0];
        IDX_TMR_CTRL:  tmr_ctrl_r   <= req.dat[REG_W-1:0];
        default:       ;  // status and unmapped ignore writes
      endcase
    end
  end

  // status view: state, oscillator enables, phi
  assign status_val = {3'h0, phi_r, CFO_EN_OUT, MAIN_OSC_EN_OUT, state_r};

  // read mux
  always_comb
  begin
    rd_val = '0;
    if (adr_ok)
    begin
      unique case (idx)
        IDX_SER1_MODE: rd_val = ser1_mode_r;
        IDX_SER2_MODE: rd_val = ser2_mode_r;
        IDX_T3_PRE:    rd_val = t3_pre_rld_r;
        IDX_T3_CNT:    rd_val = t3_cnt_r;
        IDX_TMR_CTRL:  rd_val = tmr_ctrl_r;
        IDX_STATUS:    rd_val = status_val;
        default:       rd_val = '0;  // unmapped reads zero
      endcase
    end
  end

  // wishbone ack and read data, one wait state
  always_ff @(posedge CLK_IN or posedge SYS_RST_IN)
  begin
    if (SYS_RST_IN)
    begin
      WB_ACK_OUT <= 1'b0;
      WB_DAT_OUT <= '0;
    end
    else
    begin
      WB_ACK_OUT <= req.cyc && req.stb && !WB_ACK_OUT;
      if (req.cyc && req.stb && !WB_ACK_OUT)
        WB_DAT_OUT <= {{(DAT_W-REG_W){1'b0}}, rd_val};
    end
  end

  // checks

  a_wait_phi_high: assert property (
    @(posedge CLK_IN) disable iff (SYS_RST_IN)
    (state_r == ST_WAIT) |-> (PHI_OUT && !PHI_RISE_OUT
                              && MAIN_OSC_EN_OUT == !ser2_mode_r[BIT_MAIN_HALT]))
    else $error("phi not held high in wait");

  a_wait_fast_exit: assert property (
    @(posedge CLK_IN) disable iff (SYS_RST_IN)
    (state_r == ST_WAIT && WAKE_IRQ_IN) |=> (state_r == ST_RUN))
    else $error("wait exit not immediate");

  a_wait_entry: assert property (
    @(posedge CLK_IN) disable iff (SYS_RST_IN)
    (state_r == ST_RUN && WAIT_INSTRUCTION_IN && !STOP_INSTRUCTION_IN)
    |=> (state_r == ST_WAIT && PHI_OUT && !PHI_RISE_OUT))
    else $error("wait instruction not honoured");

  a_stop_osc_off: assert property (
    @(posedge CLK_IN) disable iff (SYS_RST_IN)
    (state_r == ST_RUN && STOP_INSTRUCTION_IN) |=> (!MAIN_OSC_EN_OUT && !CFO_EN_OUT && PHI_OUT))
    else $error("oscillators still running in stop");

  a_stop_wake: assert property (
    @(posedge CLK_IN) disable iff (SYS_RST_IN)
    (state_r == ST_STOP && |STOP_WAKE_IN) |=> (state_r == ST_STAB && CFO_EN_OUT))
    else $error("stop not released by wake source");

  a_stab_phi_held: assert property (
    @(posedge CLK_IN) disable iff (SYS_RST_IN)
    (state_r == ST_STAB && !t3_ovf) |=> (state_r == ST_STAB && PHI_OUT && !PHI_RISE_OUT))
    else $error("phi released before overflow");

  a_t3_source: assert property (
    @(posedge CLK_IN) disable iff (SYS_RST_IN)
    t3_tick |-> (src_cfo ? (cfo_edge && cfo_div_r == CFO_T3_LAST)
                         : (main_edge && main_div_r == MAIN_T3_LAST)))
    else $error("wrong stabilisation input");

  a_t3_ovf_zero: assert property (
    @(posedge CLK_IN) disable iff (SYS_RST_IN)
    T3_OVF_OUT |-> ($past(state_r) == ST_STAB || state_r == ST_STAB) && t3_cnt_r == 8'h00
                   && t3_pre_r == 8'h00 ##1 (state_r == ST_RUN))
    else $error("overflow before count expired");

  a_phi_divider: assert property (
    @(posedge CLK_IN) disable iff (SYS_RST_IN)
    (state_r == ST_RUN && state_nxt == ST_RUN && phi_r != $past(phi_r, 1) && $past(state_r) == ST_RUN)
    |-> $past(src_cfo ? cfo_edge : (main_edge && main_div_r[0])))
    else $error("phi toggled without source edge");

  a_main_halt: assert property (
    @(posedge CLK_IN) disable iff (SYS_RST_IN)
    ser2_mode_r[BIT_MAIN_HALT] |-> !MAIN_OSC_EN_OUT && !main_edge)
    else $error("main oscillator runs while halted");

endmodule : clk_lp_ctrl

/* shared/clk_lp_pkg.sv */
package clk_lp_pkg;

  // register bus geometry
  localparam int unsigned ADR_W      = 12;      // byte address width
  localparam int unsigned DAT_W      = 32;      // bus data width
  localparam int unsigned SEL_W      = 4;       // byte lane selects
  localparam int unsigned REG_W      = 8;       // register width
  localparam int unsigned IDX_W      = 8;       // register index width
  localparam int unsigned IDX_LSB    = 2;       // index starts at byte address bit 2
  localparam int unsigned WAKE_W     = 5;       // stop release sources

  // register indices, byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_SER1_MODE  = 8'hf5;  // clock source select
  localparam logic [IDX_W-1:0] IDX_SER2_MODE  = 8'hf6;  // main oscillator halt
  localparam logic [IDX_W-1:0] IDX_T3_PRE     = 8'hf8;  // timer 3 prescaler reload
  localparam logic [IDX_W-1:0] IDX_T3_CNT     = 8'hf9;  // timer 3 reload on write, live count on read
  localparam logic [IDX_W-1:0] IDX_TMR_CTRL   = 8'hfa;  // timer control
  localparam logic [IDX_W-1:0] IDX_STATUS     = 8'hfb;  // read-only status

  // field positions
  localparam int unsigned BIT_SRC_SEL   = 7;    // serial 1 mode: clock function source
  localparam int unsigned BIT_MAIN_HALT = 6;    // serial 2 mode: halt main oscillator
  localparam int unsigned BIT_T3_STOP   = 5;    // timer control: timer3_count_stop_bit

  // reset values
  localparam logic [REG_W-1:0] RST_SER1_MODE = 8'h00;
  localparam logic [REG_W-1:0] RST_SER2_MODE = 8'h00;
  localparam logic [REG_W-1:0] RST_T3_PRE    = 8'hff;
  localparam logic [REG_W-1:0] RST_T3_CNT    = 8'hff;
  localparam logic [REG_W-1:0] RST_TMR_CTRL  = 8'h20;  // timer 3 stopped

  // oscillator edge dividers
  localparam logic [3:0] MAIN_T3_LAST = 4'hf;   // main divided by 16
  localparam logic [2:0] CFO_T3_LAST  = 3'h7;   // clock function divided by 8

  // low power states
  typedef enum logic [1:0] {ST_RUN, ST_WAIT, ST_STOP, ST_STAB} lp_state_t;

  // one-cycle oscillator events
  typedef struct packed {
    logic main_phi;   // main edge that toggles phi (divide by 4)
    logic main_t3;    // main divided by 16
    logic cfo_phi;    // clock function edge (divide by 2)
    logic cfo_t3;     // clock function divided by 8
  } osc_tick_t;

  // wishbone request bundle
  typedef struct packed {
    logic             cyc;
    logic             stb;
    logic             we;
    logic [ADR_W-1:0] adr;
    logic [SEL_W-1:0] sel;
    logic [DAT_W-1:0] dat;
  } wb_req_t;

endpackage : clk_lp_pkg

/* sim/osc_model.sv */
`timescale 1ns/1ps
// crystal stand-ins: free running while enabled, frozen at their level while halted
module osc_model #(
  parameter int MAIN_HALF = 2,  // main oscillator half period in clocks
  parameter int CFO_HALF  = 6   // clock function oscillator half period in clocks
)(
  input  wire logic clk_in,
  input  wire logic main_en_in,    // main oscillator allowed to swing
  input  wire logic cfo_en_in,     // clock function oscillator allowed to swing
  output logic      main_osc_out,  // main oscillator level
  output logic      cfo_osc_out    // clock function oscillator level
);
  int main_cnt_r = 0;  // clocks since last main toggle
  int cfo_cnt_r  = 0;  // clocks since last clock function toggle

  initial main_osc_out = 1'b0;
  initial cfo_osc_out  = 1'b0;

  // main oscillator swings only while enabled
  always @(posedge clk_in)
  begin
    if (main_en_in)
    begin
      main_cnt_r <= (main_cnt_r == MAIN_HALF - 1) ? 0 : main_cnt_r + 1;
      if (main_cnt_r == MAIN_HALF - 1)
        main_osc_out <= ~main_osc_out;
    end
  end

  // clock function oscillator swings only while enabled
  always @(posedge clk_in)
  begin
    if (cfo_en_in)
    begin
      cfo_cnt_r <= (cfo_cnt_r == CFO_HALF - 1) ? 0 : cfo_cnt_r + 1;
      if (cfo_cnt_r == CFO_HALF - 1)
        cfo_osc_out <= ~cfo_osc_out;
    end
  end
endmodule : osc_model

/* sim/tb_top.sv */
`timescale 1ns/1ps
`define CHK(nm, e, g) cmp(nm, 32'(e), 32'(g))
module tb_top;
  import clk_lp_pkg::*;
  logic              clk_in  = 1'b0;  // 100 MHz system clock
  logic              rst_in  = 1'b1;  // held through the first 16 cycles
  logic              wait_in = 1'b0;  // wait instruction pulse
  logic              stop_in = 1'b0;  // stop instruction pulse
  logic              irq_in  = 1'b0;  // enabled interrupt pending
  logic [WAKE_W-1:0] wake_in = '0;    // stop release sources
  wb_req_t           req     = '0;    // bus request bundle
  logic [DAT_W-1:0]  rdat, rd;
  logic              ack, phi, rise, m_en, c_en, ovf, m_osc, c_osc;
  int                err_total   = 0;
  int                check_count = 0;
  int                exp_reg [int];   // register image after reset
  int                n, k, cyc, pre, t3, per;

  always #5 clk_in = ~clk_in;

  clk_lp_ctrl i_clk_lp_ctrl (.CLK_IN(clk_in), .SYS_RST_IN(rst_in), .MAIN_OSC_IN(m_osc),
    .CLOCK_FUNCTION_OSC_INPUT_IN(c_osc), .WAIT_INSTRUCTION_IN(wait_in),
    .STOP_INSTRUCTION_IN(stop_in), .WAKE_IRQ_IN(irq_in), .STOP_WAKE_IN(wake_in),
    .WB_CYC_IN(req.cyc), .WB_STB_IN(req.stb), .WB_WE_IN(req.we), .WB_ADR_IN(req.adr),
    .WB_SEL_IN(req.sel), .WB_DAT_IN(req.dat), .WB_DAT_OUT(rdat), .WB_ACK_OUT(ack),
    .PHI_OUT(phi), .PHI_RISE_OUT(rise), .MAIN_OSC_EN_OUT(m_en), .CFO_EN_OUT(c_en),
    .T3_OVF_OUT(ovf));

  osc_model i_osc_model (.clk_in(clk_in), .main_en_in(m_en), .cfo_en_in(c_en),
    .main_osc_out(m_osc), .cfo_osc_out(c_osc));

  // counts a comparison, reports a mismatch
  task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e)
    begin
      err_total++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask : cmp

  // one classic bus cycle, entered just after a rising edge
  task automatic wb(input logic we, input logic [IDX_W-1:0] idx, input logic [7:0] d);
    int w;
    req <= '{1'b1, 1'b1, we, {2'b00, idx, 2'b00}, 4'h1, {24'h0, d}};
    w = 0;
    do
    begin
      @(posedge clk_in);
      w++;
    end
    while (ack !== 1'b1 && w < 50);
    `CHK("bus ack", 1, ack);
    rd = rdat;
    req <= '0;
    @(posedge clk_in);
  endtask : wb

  // edges from one phi rise to the next
  task automatic period(output int p);
    int q;
    q = 0;
    while (rise !== 1'b1 && q < 400)
    begin
      @(posedge clk_in);
      q++;
    end
    @(posedge clk_in);
    p = 1;
    while (rise !== 1'b1 && p < 400)
    begin
      @(posedge clk_in);
      p++;
    end
  endtask : period

  // verdict and end of run
  task automatic wrap_up;
    $display("checks %0d errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : wrap_up

  // cuts a hang short
  initial
  begin
    #500000;
    err_total++;
    wrap_up();
  end

  // main sequence
  initial
  begin
    void'($urandom(16276));
    exp_reg = '{'hf5: 0, 'hf6: 0, 'hf8: 255, 'hf9: 255, 'hfa: 32, 'h00: 0, 'h40: 0};
    repeat (16) @(posedge clk_in);
    `CHK("phi in reset", 1, phi);
    `CHK("osc on in reset", 3, {m_en, c_en});
    rst_in <= 1'b0;
    @(posedge clk_in);
    foreach (exp_reg[i])
    begin
      wb(1'b0, 8'(i), 8'h00);
      `CHK("reset register", exp_reg[i], rd);
    end
    period(n);
    `CHK("phi period main", 16, n);
    wb(1'b1, IDX_SER1_MODE, 8'h80);
    period(n);
    period(n);
    `CHK("phi period cfo", 24, n);
    wb(1'b1, IDX_SER2_MODE, 8'h40);
    `CHK("main halted", 0, m_en);
    wb(1'b1, IDX_SER2_MODE, 8'h00);
    `CHK("main restarted", 1, m_en);
    // software settling wait after restart
    repeat (40) @(posedge clk_in);
    wb(1'b1, IDX_SER1_MODE, 8'h00);
    period(n);
    period(n);
    `CHK("phi period back", 16, n);
    // wait with random dwell; waking interrupt counted as enabled
    for (int i = 0; i < 3; i++)
    begin
      wait_in <= 1'b1;
      @(posedge clk_in);
      wait_in <= 1'b0;
      repeat (2) @(posedge clk_in);
      cyc = 10 + $urandom_range(40);
      k = 0;
      repeat (cyc)
      begin
        @(posedge clk_in);
        if (phi !== 1'b1 || rise !== 1'b0)
          k++;
      end
      `CHK("phi held in wait", 0, k);
      `CHK("osc runs in wait", 3, {m_en, c_en});
      irq_in <= 1'b1;
      @(posedge clk_in);
      irq_in <= 1'b0;
      k = 0;
      while (rise !== 1'b1 && k < 100)
      begin
        @(posedge clk_in);
        k++;
      end
      `CHK("wait exit prompt", 1, k <= 18);
    end
    // stop, released by each source in turn; live timer never sampled
    for (int i = 0; i < WAKE_W; i++)
    begin
      pre = $urandom_range(2);
      t3 = $urandom_range(2);
      per = i[0] ? 96 : 64;
      wb(1'b1, IDX_SER1_MODE, {i[0], 7'h00});
      wb(1'b1, IDX_T3_PRE, 8'(pre));
      wb(1'b1, IDX_T3_CNT, 8'(t3));
      wb(1'b1, IDX_TMR_CTRL, 8'h00);
      stop_in <= 1'b1;
      @(posedge clk_in);
      stop_in <= 1'b0;
      repeat (20) @(posedge clk_in);
      `CHK("osc off in stop", 0, {m_en, c_en});
      `CHK("phi high in stop", 1, phi);
      wake_in <= WAKE_W'(1 << i);
      @(posedge clk_in);
      wake_in <= '0;
      n = (pre + 1) * (t3 + 1) * per;
      cyc = 0;
      k = 0;
      while (ovf !== 1'b1 && cyc < n + 200)
      begin
        @(posedge clk_in);
        cyc++;
        if (phi !== 1'b1)
          k++;
      end
      `CHK("osc restart", 3, {m_en, c_en});
      `CHK("stab span", 1, cyc > n - per && cyc <= n + 12);
      `CHK("phi held in stab", 0, k);
      @(posedge clk_in);
      wb(1'b0, IDX_STATUS, 8'h00);
      `CHK("run after stab", 0, rd[1:0]);
      wb(1'b0, IDX_T3_PRE, 8'h00);
      `CHK("state kept in stop", pre, rd);
    end
    // reset while waiting with main halted; reset held long for settling
    wb(1'b1, IDX_SER1_MODE, 8'h80);
    wb(1'b1, IDX_SER2_MODE, 8'h40);
    wait_in <= 1'b1;
    @(posedge clk_in);
    wait_in <= 1'b0;
    repeat (5) @(posedge clk_in);
    rst_in <= 1'b1;
    repeat (16) @(posedge clk_in);
    rst_in <= 1'b0;
    @(posedge clk_in);
    `CHK("main on after reset", 1, m_en);
    wb(1'b0, IDX_SER1_MODE, 8'h00);
    `CHK("source after reset", 0, rd);
    wb(1'b0, IDX_STATUS, 8'h00);
    `CHK("run after reset", 0, rd[1:0]);
    wrap_up();
  end
endmodule : tb_top
